// [hw/dcae_pkg.sv]
/*
 * Shared constants and types for the DDR4 command/address encoder.
 * Assumes a controller clock of 100 MHz and a memory clock from the PHY.
 */
package dcae_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W  = 17;
	localparam int RANKS   = 4;
	localparam int COL_W   = 10;
	localparam int MRD_W   = 14;

	// ----------------------------------------------------------------
	// Address bit positions
	// ----------------------------------------------------------------
	localparam int POS_RAS    = 16;
	localparam int POS_CAS    = 15;
	localparam int POS_WE     = 14;
	localparam int POS_AP     = 10;
	localparam int POS_BC     = 12;

	// ----------------------------------------------------------------
	// Command codes on row strobe, column strobe and write enable
	// ----------------------------------------------------------------
	localparam logic [2:0] CODE_MRS = 3'h0;
	localparam logic [2:0] CODE_REF = 3'h1;
	localparam logic [2:0] CODE_PRE = 3'h2;
	localparam logic [2:0] CODE_WR  = 3'h4;
	localparam logic [2:0] CODE_RD  = 3'h5;
	localparam logic [2:0] CODE_NOP = 3'h7;

	// ----------------------------------------------------------------
	// Mode register holding the write CRC enable, and that bit
	// ----------------------------------------------------------------
	localparam logic [2:0] MR_CRC_SEL = 3'h2;
	localparam int         MR_CRC_BIT = 12;

	// ----------------------------------------------------------------
	// Reset and idle values
	// ----------------------------------------------------------------
	localparam logic [RANKS-1:0]  CS_IDLE   = 4'hf;
	localparam logic [ADDR_W-1:0] ADDR_IDLE = 17'h1c000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		DCAE_NOP = 3'h0,
		DCAE_ACT = 3'h1,
		DCAE_RD  = 3'h2,
		DCAE_WR  = 3'h3,
		DCAE_PRE = 3'h4,
		DCAE_REF = 3'h5,
		DCAE_MRS = 3'h6
	} dcae_cmd_t;

	typedef enum logic [2:0] {
		S_IDLE  = 3'h1,
		S_HOLD  = 3'h2,
		S_DRIVE = 3'h4
	} dcae_state_t;

endpackage : dcae_pkg

// [hw/dcae_encoder.sv]
/*
 * One channel of the DDR4 command/address encoder: encodes a command,
 * launches it on the falling edge of the true memory clock and watches alert.
 * Assumes the memory clock and alert arrive asynchronously to i_clk.
 */
`timescale 1ns/1ps

module dcae_encoder
	import dcae_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_arst_n,
	input  wire logic              i_mem_clock_true,
	input  wire logic              i_cmd_valid,
	input  wire dcae_cmd_t         i_cmd_kind,
	input  wire logic [1:0]        i_cmd_rank,
	input  wire logic [1:0]        i_cmd_bank_group,
	input  wire logic [1:0]        i_cmd_bank,
	input  wire logic [ADDR_W-1:0] i_cmd_row,
	input  wire logic [COL_W-1:0]  i_cmd_col,
	input  wire logic              i_cmd_auto_precharge,
	input  wire logic              i_cmd_full_burst,
	input  wire logic              i_cmd_all_banks,
	input  wire logic [2:0]        i_cmd_mode_reg,
	input  wire logic [MRD_W-1:0]  i_cmd_mode_data,
	input  wire logic [RANKS-1:0]  i_rank_clock_enable,
	input  wire logic [RANKS-1:0]  i_rank_term_enable,
	input  wire logic              i_training,
	input  wire logic              i_chan_parity_alert_n,
	output logic                   o_cmd_ready,
	output logic [ADDR_W-1:0]      o_chan_mem_addr_bus,
	output logic [RANKS-1:0]       o_chan_rank_select_n,
	output logic [RANKS-1:0]       o_chan_rank_term_enable,
	output logic [RANKS-1:0]       o_chan_rank_clock_enable,
	output logic                   o_chan_activate_qualifier_n,
	output logic [1:0]             o_chan_bank_group_sel,
	output logic [1:0]             o_chan_bank_sel,
	output logic                   o_chan_cmd_parity,
	output logic                   o_parity_error
);

	// ----------------------------------------------------------------
	// Synchronisers and edge detection
	// ----------------------------------------------------------------
	logic        clk_s1, clk_s2, clk_s3;
	logic        alt_s1, alt_s2, alt_s3;
	wire  logic  clk_fall  = clk_s3 & ~clk_s2;
	wire  logic  alert_low = alt_s3 & ~alt_s2;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			{clk_s1, clk_s2, clk_s3} <= 3'h0;
			{alt_s1, alt_s2, alt_s3} <= 3'h7;
		end else begin
			{clk_s3, clk_s2, clk_s1} <= {clk_s2, clk_s1, i_mem_clock_true};
			{alt_s3, alt_s2, alt_s1} <= {alt_s2, alt_s1, i_chan_parity_alert_n};
		end
	end

	// ----------------------------------------------------------------
	// Command encoding
	// ----------------------------------------------------------------
	wire logic is_act = (i_cmd_kind == DCAE_ACT);
	wire logic is_rd  = (i_cmd_kind == DCAE_RD);
	wire logic is_wr  = (i_cmd_kind == DCAE_WR);
	wire logic is_pre = (i_cmd_kind == DCAE_PRE);
	wire logic is_ref = (i_cmd_kind == DCAE_REF);
	wire logic is_mrs = (i_cmd_kind == DCAE_MRS);
	wire logic is_nop = ~(is_act | is_rd | is_wr | is_pre | is_ref | is_mrs);

	wire logic [2:0] enc_code = is_rd  ? CODE_RD  :
	                            is_wr  ? CODE_WR  :
	                            is_pre ? CODE_PRE :
	                            is_ref ? CODE_REF :
	                            is_mrs ? CODE_MRS : CODE_NOP;

	// The write CRC enable (bit MR_CRC_BIT) is forced off only in writes to mode register MR_CRC_SEL.
	wire logic       mr_crc   = (i_cmd_mode_reg == MR_CRC_SEL);
	wire logic [MRD_W-1:0] mr_data = i_cmd_mode_data &
	                                 ~(mr_crc ? (14'h1 << MR_CRC_BIT) : 14'h0);

	wire logic [ADDR_W-1:0] acc_addr = {enc_code, 1'b0, i_cmd_full_burst, 1'b0,
	                                    i_cmd_auto_precharge, i_cmd_col};
	wire logic [ADDR_W-1:0] pre_addr = {enc_code, 3'h0, i_cmd_all_banks, 10'h0};
	wire logic [ADDR_W-1:0] enc_addr = is_act ? i_cmd_row :
	                                   (is_rd | is_wr) ? acc_addr :
	                                   is_pre ? pre_addr :
	                                   is_mrs ? {enc_code, mr_data} :
	                                   {enc_code, 14'h0};

	wire logic       enc_act_n = ~is_act;
	wire logic       bank_cmd  = is_act | is_rd | is_wr | (is_pre & ~i_cmd_all_banks);
	wire logic [1:0] enc_bg    = bank_cmd ? i_cmd_bank_group :
	                             is_mrs ? {1'b0, i_cmd_mode_reg[2]} : 2'h0;
	wire logic [1:0] enc_ba    = bank_cmd ? i_cmd_bank :
	                             is_mrs ? i_cmd_mode_reg[1:0] : 2'h0;
	wire logic [RANKS-1:0] enc_cs_n = is_nop ? CS_IDLE :
	                                  ~(4'h1 << i_cmd_rank);
	wire logic       enc_par   = ^{enc_act_n, enc_addr, enc_bg, enc_ba};

	// ----------------------------------------------------------------
	// Launch sequencing
	// ----------------------------------------------------------------
	dcae_state_t state, next_state;
	logic [ADDR_W-1:0] pend_addr;
	logic [RANKS-1:0]  pend_cs_n;
	logic [1:0]        pend_bg, pend_ba;
	logic              pend_act_n, pend_par;

	wire logic accept = i_cmd_valid & (state == S_IDLE);
	wire logic launch = clk_fall & (state == S_HOLD);
	wire logic retire = clk_fall & (state == S_DRIVE);

	always_comb begin
		case (state)
			S_IDLE:  next_state = accept ? S_HOLD : S_IDLE;
			S_HOLD:  next_state = clk_fall ? S_DRIVE : S_HOLD;
			S_DRIVE: next_state = clk_fall ? S_IDLE : S_DRIVE;
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state       <= S_IDLE;
			o_cmd_ready <= 1'b1;
		end else begin
			state       <= next_state;
			o_cmd_ready <= (next_state == S_IDLE);
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			{pend_addr, pend_cs_n, pend_bg, pend_ba, pend_act_n, pend_par} <=
				{ADDR_IDLE, CS_IDLE, 4'h0, 1'b1, 1'b0};
		end else if (accept) begin
			{pend_addr, pend_cs_n, pend_bg, pend_ba, pend_act_n, pend_par} <=
				{enc_addr, enc_cs_n, enc_bg, enc_ba, enc_act_n, enc_par};
		end
	end

	// Bus changes only on a detected fall of the true memory clock.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_chan_mem_addr_bus         <= ADDR_IDLE;
			o_chan_rank_select_n        <= CS_IDLE;
			o_chan_bank_group_sel       <= 2'h0;
			o_chan_bank_sel             <= 2'h0;
			o_chan_activate_qualifier_n <= 1'b1;
			o_chan_cmd_parity           <= 1'b0;
		end else if (launch) begin
			o_chan_mem_addr_bus         <= pend_addr;
			o_chan_rank_select_n        <= pend_cs_n;
			o_chan_bank_group_sel       <= pend_bg;
			o_chan_bank_sel             <= pend_ba;
			o_chan_activate_qualifier_n <= pend_act_n;
			o_chan_cmd_parity           <= pend_par;
		end else if (retire) begin
			o_chan_mem_addr_bus         <= ADDR_IDLE;
			o_chan_rank_select_n        <= CS_IDLE;
			o_chan_bank_group_sel       <= 2'h0;
			o_chan_bank_sel             <= 2'h0;
			o_chan_activate_qualifier_n <= 1'b1;
			o_chan_cmd_parity           <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Per-rank clock enable and termination, and alert reporting
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_chan_rank_clock_enable <= 4'h0;
			o_chan_rank_term_enable  <= 4'h0;
		end else if (clk_fall) begin
			o_chan_rank_clock_enable <= i_rank_clock_enable;
			o_chan_rank_term_enable  <= i_rank_term_enable;
		end
	end

	// Alert is only a parity flag in training and never a CRC report.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_parity_error <= 1'b0;
		end else begin
			o_parity_error <= alert_low & i_training;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	rank_onehot_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		$onehot0(~o_chan_rank_select_n))
		else $error("More than one rank select asserted.");

	parity_even_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(^{o_chan_cmd_parity, o_chan_activate_qualifier_n, o_chan_mem_addr_bus,
		   o_chan_bank_group_sel, o_chan_bank_sel}) == 1'b0)
		else $error("Command parity is not even.");

	launch_edge_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		!$stable(o_chan_mem_addr_bus) |-> $past(clk_fall))
		else $error("Address bus changed away from a memory clock fall.");

	act_select_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		!o_chan_activate_qualifier_n |-> o_chan_rank_select_n != CS_IDLE)
		else $error("Activate driven without a rank select.");

	alert_ignored_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		alert_low && !i_training |=> !o_parity_error)
		else $error("Alert reported outside command training.");

	alert_report_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		alert_low && i_training |=> o_parity_error)
		else $error("Training alert not reported.");

	crc_off_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_chan_rank_select_n != CS_IDLE && o_chan_activate_qualifier_n &&
		o_chan_mem_addr_bus[POS_RAS:POS_WE] == CODE_MRS &&
		{o_chan_bank_group_sel[0], o_chan_bank_sel} == MR_CRC_SEL
		|-> !o_chan_mem_addr_bus[MR_CRC_BIT])
		else $error("Write CRC enable written to the mode register.");

	cmd_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		launch && pend_cs_n != CS_IDLE |=> (o_chan_rank_select_n != CS_IDLE)[*3])
		else $error("Command did not stay on the bus.");

	accept_launch_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		accept && is_act |-> ##[1:20] !o_chan_activate_qualifier_n)
		else $error("Accepted activate never reached the bus.");

	act_cover_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		launch && !pend_act_n);

	rd_ap_cover_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		launch && pend_addr[POS_RAS:POS_WE] == CODE_RD && pend_addr[POS_AP]);

	pre_all_cover_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		launch && pend_addr[POS_RAS:POS_WE] == CODE_PRE && pend_addr[POS_AP]);

	alert_cover_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
		o_parity_error);

endmodule : dcae_encoder

// [testbench/dcae_sdram_model.sv]
/*
 * Rank-side model: free-running memory clock and an alert pin that
 * falls on a bad command parity or when the bench injects an error.
 * Assumes the encoder's pins are wired straight across to it.
 */
`timescale 1ns/1ps

module dcae_sdram_model
	import dcae_pkg::*;
(
	input  wire logic              i_inject,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [RANKS-1:0]  i_select_n,
	input  wire logic              i_act_n,
	input  wire logic [1:0]        i_bg,
	input  wire logic [1:0]        i_ba,
	input  wire logic              i_parity,
	output logic                   o_mem_clock_true,
	output logic                   o_alert_n
);
	initial begin
		o_mem_clock_true = 1'b0;
		#3;
		forever #40 o_mem_clock_true = ~o_mem_clock_true;
	end

	// Sample at the rising memory clock; a parity fault pulls alert low.
	always @(posedge o_mem_clock_true) begin
		if ((i_select_n != CS_IDLE && ^{i_parity, i_act_n, i_addr, i_bg, i_ba}) ||
		    i_inject) begin
			o_alert_n <= 1'b0;
		end else begin
			o_alert_n <= 1'b1;
		end
	end
endmodule : dcae_sdram_model

// [testbench/dcae_encoder_test.sv]
/*
 * Self-checking bench for one command/address encoder channel.
 * Assumes the rank model supplies the memory clock and alert pin.
 */
`timescale 1ns/1ps

module dcae_encoder_test
	import dcae_pkg::*;
;
	logic              i_clk;
	logic              i_arst_n;
	logic              valid;
	logic              training;
	logic              inject;
	dcae_cmd_t         kind;
	logic [31:0]       sv;
	logic [31:0]       sw;
	logic [RANKS-1:0]  cke;
	logic [RANKS-1:0]  odt;
	logic [RANKS-1:0]  seen;
	wire               mclk;
	wire               alert_n;
	wire               ready;
	wire               act_n;
	wire               par;
	wire               perr;
	wire  [ADDR_W-1:0] addr;
	wire  [RANKS-1:0]  cs_n;
	wire  [RANKS-1:0]  odt_o;
	wire  [RANKS-1:0]  cke_o;
	wire  [1:0]        bg_o;
	wire  [1:0]        ba_o;
	int                miscompares;
	int                comparisons;
	int                seed;
	int                npulse;
	logic [25:0]       exp_q[$];
	logic [25:0]       msk_q[$];

	dcae_encoder dcae_encoder_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_mem_clock_true(mclk),
		.i_cmd_valid(valid), .i_cmd_kind(kind), .i_cmd_rank(sv[1:0]), .i_cmd_bank(sv[3:2]),
		.i_cmd_bank_group(sv[5:4]), .i_cmd_auto_precharge(sv[6]), .i_cmd_full_burst(sv[7]),
		.i_cmd_all_banks(sv[8]), .i_cmd_mode_reg(sv[11:9]), .i_cmd_col(sv[21:12]),
		.i_cmd_row(sw[16:0]), .i_cmd_mode_data(sw[30:17]), .i_rank_clock_enable(cke),
		.i_rank_term_enable(odt), .i_training(training), .i_chan_parity_alert_n(alert_n),
		.o_cmd_ready(ready), .o_chan_mem_addr_bus(addr), .o_chan_rank_select_n(cs_n),
		.o_chan_rank_term_enable(odt_o), .o_chan_rank_clock_enable(cke_o),
		.o_chan_activate_qualifier_n(act_n), .o_chan_bank_group_sel(bg_o),
		.o_chan_bank_sel(ba_o), .o_chan_cmd_parity(par), .o_parity_error(perr));

	dcae_sdram_model dcae_sdram_model_i (.i_inject(inject), .i_addr(addr), .i_select_n(cs_n),
		.i_act_n(act_n), .i_bg(bg_o), .i_ba(ba_o), .i_parity(par),
		.o_mem_clock_true(mclk), .o_alert_n(alert_n));

	always #5 i_clk = ~i_clk;

	task automatic check(input string what, input logic [25:0] e, input logic [25:0] g);
		comparisons++;
		if (e !== g) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : check

	task automatic test_done;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done

	task automatic wait_cycles(input int n);
		repeat (n) @(posedge i_clk);
	endtask : wait_cycles

	// Notes the expected bus word, then hands the command over.
	task automatic issue(input dcae_cmd_t k);
		logic [31:0] v;
		logic [31:0] w;
		logic [13:0] md;
		logic [3:0]  cs;
		logic [25:0] e;
		logic [25:0] m;
		int          n;
		v = $random(seed);
		w = $random(seed);
		if (k == DCAE_MRS && v[31]) begin
			v[11:9] = MR_CRC_SEL;
		end
		cs = ~(4'h1 << v[1:0]);
		md = w[30:17];
		if (v[11:9] == MR_CRC_SEL) begin
			md[MR_CRC_BIT] = 1'b0;
		end
		m = '1;
		e = '0;
		case (k)
			DCAE_ACT: e = {1'b0, w[16:0], v[5:2], cs};
			DCAE_RD, DCAE_WR: e = {1'b1, (k == DCAE_RD) ? CODE_RD : CODE_WR, 1'b0, v[7], 1'b0,
				v[6], v[21:12], v[5:2], cs};
			DCAE_PRE: begin
				e = {1'b1, CODE_PRE, 3'h0, v[8], 10'h0, v[8] ? 4'h0 : v[5:2], cs};
				m = 26'h3c400ff;
			end
			DCAE_REF: begin
				e = {1'b1, CODE_REF, 18'h0, cs};
				m = 26'h3c0000f;
			end
			DCAE_MRS: e = {1'b1, CODE_MRS, md, 1'b0, v[11:9], cs};
			default: e = '0;
		endcase
		if (k != DCAE_NOP) begin
			exp_q.push_back(e);
			msk_q.push_back(m);
		end
		@(posedge i_clk);
		sv <= v;
		sw <= w;
		kind <= k;
		valid <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (ready !== 1'b1 && n < 40);
		valid <= 1'b0;
		if (n >= 40) begin
			miscompares++;
			test_done();
		end
		wait_cycles(24);
	endtask : issue

	// Takes the oldest note off the queue as each command reaches the bus.
	always @(negedge i_clk) begin
		if (perr === 1'b1) begin
			npulse++;
		end
		if (seen === CS_IDLE && cs_n !== CS_IDLE) begin
			if (exp_q.size() == 0) begin
				check("unexpected command", 26'h0, 26'h1);
			end else begin
				check("command", exp_q[0] & msk_q[0], {act_n, addr, bg_o, ba_o, cs_n} & msk_q[0]);
				check("parity", 26'h0, {25'h0, ^{par, act_n, addr, bg_o, ba_o}});
				void'(exp_q.pop_front());
				void'(msk_q.pop_front());
			end
		end
		seen = cs_n;
	end

	initial begin
		seed = 32'hb4f6;
		i_clk = 1'b0;
		i_arst_n = 1'b0;
		valid = 1'b0;
		training = 1'b0;
		inject = 1'b0;
		kind = DCAE_NOP;
		sv = '0;
		sw = '0;
		cke = '0;
		odt = '0;
		seen = CS_IDLE;
		wait_cycles(12);
		check("reset", 26'h3e00, {12'h0, ready, cs_n, cke_o, odt_o, perr});
		i_arst_n <= 1'b1;
		training <= 1'b1;
		for (int j = 0; j < 35; j++) begin
			issue(dcae_cmd_t'(j % 7));
		end
		check("left over", 26'h0, 26'(exp_q.size()));
		check("false alert", 26'h0, 26'(npulse));
		$display("test commands done");
		for (int j = 0; j < 4; j++) begin
			@(posedge i_clk);
			cke <= 4'($random(seed));
			odt <= 4'($random(seed));
			wait_cycles(24);
			check("cke odt", {18'h0, cke, odt}, {18'h0, cke_o, odt_o});
		end
		$display("test enables done");
		inject <= 1'b1;
		wait_cycles(12);
		inject <= 1'b0;
		wait_cycles(30);
		check("alert in training", 26'h1, 26'(npulse));
		training <= 1'b0;
		inject <= 1'b1;
		wait_cycles(12);
		inject <= 1'b0;
		wait_cycles(30);
		check("alert outside training", 26'h1, 26'(npulse));
		$display("test alert done");
		test_done();
	end
endmodule : dcae_encoder_test
